/* design/ubb_fifo.sv */
/*
 ubb_fifo: show-ahead FIFO, storage and head word held in flip-flops.
 Assumes a single clock; clr empties it in one cycle.
*/
`timescale 1ns/1ps
module ubb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clr,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ubb_fifo

/* design/ubb_pkg.sv */
/*
 ubb_pkg: addresses, field positions, reset values, timing counts and types
 of the burst alias receive/transmit buffer block.
 Assumes one 200 MHz clock and an APB master with 32-bit data.
*/
// Behaviour
// - sixteen word-spaced alias locations read the receive buffer and write transmit holding.
// - an alias read returns the received byte in bits 7:0, serial or infrared.
// - read data is valid only while the data-ready flag is set.
// - with FIFOs off a new byte overwrites an unread one and flags overrun.
// - with FIFOs on an alias read returns the head of the receive FIFO.
// - a byte arriving at a full receive FIFO is dropped and flags overrun.
// - an alias write sends a byte on serial or active-low infrared output.
// - with FIFOs off one write clears the transmit-holding-empty flag.
// - with FIFOs off further writes before empty overwrite the pending byte.
// - with FIFOs on the transmit FIFO accepts sixteen bytes before full.
// - a write to a full transmit FIFO is dropped, contents unchanged.
package ubb_pkg;
  localparam logic [31:0] ALIAS_BASE = 32'h5000_1130;
  localparam logic [31:0] ALIAS_LAST = 32'h5000_116c;
  localparam logic [31:0] ALIAS_5_ADDR = 32'h5000_1144;
  localparam logic [31:0] ALIAS_6_ADDR = 32'h5000_1148;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1200;
  localparam logic [31:0] STAT_ADDR = 32'h5000_1204;
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_BIT = 1;
  localparam int STAT_DR_BIT = 0;
  localparam int STAT_OE_BIT = 1;
  localparam int STAT_TRANSMIT_HOLDING_EMPTY_FLAG_BIT = 5;
  localparam int STAT_TEMT_BIT = 6;
  localparam int STAT_TXF_BIT = 8;
  localparam int STAT_RXF_BIT = 9;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam logic [10:0] BIT_CYC = 11'(CLK_HZ / BAUD_HZ);
  localparam logic [10:0] HALF_CYC = 11'(CLK_HZ / BAUD_HZ / 2);

  typedef struct packed {
    logic ir_mode;
    logic fifo_en;
  } ubb_ctrl_t;

  localparam ubb_ctrl_t CTRL_RST = '{ir_mode: 1'b0, fifo_en: 1'b0};

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ubb_apb_req_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b10,
    SER_STOP = 2'b11
  } ubb_ser_st_t;

  function automatic logic ubb_is_alias(input logic [31:0] a);
    ubb_is_alias = (a >= ALIAS_BASE) && (a <= ALIAS_LAST) && (a[1:0] == 2'b00);
  endfunction : ubb_is_alias
endpackage : ubb_pkg

/* design/ubb_sync.sv */
/*
 ubb_sync: two-flop synchroniser for a pin level.
 Assumes the pin is asynchronous to clock; idles at RST_VAL.
*/
`timescale 1ns/1ps
module ubb_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : ubb_sync

/* design/ubb_top.sv */
/*
 ubb_top: APB slave with sixteen alias words onto receive buffer and
 transmit holding, 8N1 serial and infrared engines, receive and transmit FIFOs.
 Assumes APB master on clock; sin and sir_in are asynchronous pins.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module ubb_top
  import ubb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial and infrared link
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n
);
  import ubb_pkg::*;

  ubb_apb_req_t req;
  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

  // address decode
  wire hit_alias = ubb_is_alias(req.addr);
  wire hit_ctrl = (req.addr == CTRL_ADDR);
  wire hit_stat = (req.addr == STAT_ADDR);
  wire hit_any = hit_alias || hit_ctrl || hit_stat;
  wire setup = req.sel && !req.en;
  wire access = req.sel && req.en;
  wire wr_acc = access && req.wr;
  wire rd_acc = access && !req.wr;
  wire alias_wr = wr_acc && hit_alias;
  wire ctrl_wr = wr_acc && hit_ctrl;
  wire stat_rd = rd_acc && hit_stat;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // control register
  ubb_ctrl_t ctrl_q;
  wire ubb_ctrl_t ctrl_d = '{ir_mode: req.wdata[CTRL_IR_BIT],
                             fifo_en: req.wdata[CTRL_FIFO_EN_BIT]};
  wire fifo_en = ctrl_q.fifo_en;
  wire fifo_clr = ctrl_wr && (ctrl_d.fifo_en != ctrl_q.fifo_en);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_d;
    end
  end

  // pin synchronisers
  logic sin_s;
  logic sir_in_s;

  ubb_sync #(.RST_VAL(1'b1)) u_sync_sin (
    .clock(clock),
    .rstn(rstn),
    .din(sin),
    .dout(sin_s)
  );

  ubb_sync #(.RST_VAL(1'b0)) u_sync_sir (
    .clock(clock),
    .rstn(rstn),
    .din(sir_in),
    .dout(sir_in_s)
  );

  // infrared input pulses high for a zero bit
  wire rx_line = ctrl_q.ir_mode ? !sir_in_s : sin_s;

  // receive engine
  ubb_ser_st_t rx_st_q;
  logic [10:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_done_q;
  wire rx_tick = (rx_cnt_q == 11'h000);
  wire [7:0] rx_sh_d = {rx_line, rx_sh_q[7:1]};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= SER_IDLE;
      rx_cnt_q <= 11'h000;
      rx_idx_q <= 3'h0;
      rx_sh_q <= BUF_RST;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rx_cnt_q <= rx_tick ? BIT_CYC - 11'h001 : rx_cnt_q - 11'h001;
      case (rx_st_q)
        SER_IDLE: begin
          rx_cnt_q <= HALF_CYC;
          if (!rx_line) begin
            rx_st_q <= SER_START;
          end
        end
        SER_START: begin
          if (rx_tick) begin
            rx_st_q <= rx_line ? SER_IDLE : SER_DATA;
            rx_idx_q <= 3'h0;
          end
        end
        SER_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= rx_sh_d;
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) begin
              rx_st_q <= SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (rx_tick) begin
            rx_done_q <= rx_line;
            rx_st_q <= SER_IDLE;
          end
        end
        default: begin
          rx_st_q <= SER_IDLE;
        end
      endcase
    end
  end

  // receive FIFO
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic [7:0] rxf_out_data;
  logic rd_ok_q;
  wire alias_rd = rd_acc && hit_alias && rd_ok_q;

  ubb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock(clock),
    .rstn(rstn),
    .clr(fifo_clr),
    .in_valid(rx_done_q && fifo_en),
    .in_ready(rxf_in_ready),
    .in_data(rx_sh_q),
    .out_valid(rxf_out_valid),
    .out_ready(alias_rd && fifo_en),
    .out_data(rxf_out_data)
  );

  // single receive holding register when FIFOs are off
  logic [7:0] rx_hold_q;
  logic rx_dr_q;
  logic overrun_q;
  wire hold_clr = alias_rd && !fifo_en;
  wire ovr_hold = rx_done_q && !fifo_en && rx_dr_q && !hold_clr;
  wire ovr_fifo = rx_done_q && fifo_en && !rxf_in_ready;
  wire data_ready = fifo_en ? rxf_out_valid : rx_dr_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_hold_q <= BUF_RST;
      rx_dr_q <= 1'b0;
    end else if (rx_done_q && !fifo_en) begin
      rx_hold_q <= rx_sh_q;
      rx_dr_q <= 1'b1;
    end else if (hold_clr || fifo_clr) begin
      rx_dr_q <= 1'b0;
    end
  end

  // overrun: a new event wins over the clear-on-status-read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      overrun_q <= 1'b0;
    end else if (ovr_hold || ovr_fifo) begin
      overrun_q <= 1'b1;
    end else if (stat_rd) begin
      overrun_q <= 1'b0;
    end
  end

  // transmit FIFO and single holding register
  logic txf_in_ready;
  logic txf_out_valid;
  logic [7:0] txf_out_data;
  logic [7:0] tx_hold_q;
  logic transmit_holding_empty_flag_q;
  logic tx_load;

  ubb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clock(clock),
    .rstn(rstn),
    .clr(fifo_clr),
    .in_valid(alias_wr && fifo_en),
    .in_ready(txf_in_ready),
    .in_data(req.wdata[7:0]),
    .out_valid(txf_out_valid),
    .out_ready(tx_load && fifo_en),
    .out_data(txf_out_data)
  );

  wire transmit_holding_empty_flag = fifo_en ? !txf_out_valid : transmit_holding_empty_flag_q;
  wire tx_src_valid = fifo_en ? txf_out_valid : !transmit_holding_empty_flag_q;
  wire [7:0] tx_src_data = fifo_en ? txf_out_data : tx_hold_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_hold_q <= BUF_RST;
      transmit_holding_empty_flag_q <= 1'b1;
    end else if (alias_wr && !fifo_en) begin
      tx_hold_q <= req.wdata[7:0];
      transmit_holding_empty_flag_q <= 1'b0;
    end else if ((tx_load && !fifo_en) || fifo_clr) begin
      transmit_holding_empty_flag_q <= 1'b1;
    end
  end

  // transmit engine
  ubb_ser_st_t tx_st_q;
  logic [10:0] tx_cnt_q;
  logic [2:0] tx_idx_q;
  logic [7:0] tx_sh_q;
  logic tx_bit_q;
  wire tx_tick = (tx_cnt_q == 11'h000);
  assign tx_load = (tx_st_q == SER_IDLE) && tx_src_valid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= SER_IDLE;
      tx_cnt_q <= 11'h000;
      tx_idx_q <= 3'h0;
      tx_sh_q <= BUF_RST;
      tx_bit_q <= 1'b1;
    end else begin
      tx_cnt_q <= tx_tick ? BIT_CYC - 11'h001 : tx_cnt_q - 11'h001;
      case (tx_st_q)
        SER_IDLE: begin
          tx_bit_q <= 1'b1;
          if (tx_load) begin
            tx_sh_q <= tx_src_data;
            tx_bit_q <= 1'b0;
            tx_cnt_q <= BIT_CYC - 11'h001;
            tx_st_q <= SER_START;
          end
        end
        SER_START: begin
          if (tx_tick) begin
            tx_bit_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            tx_idx_q <= 3'h0;
            tx_st_q <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (tx_tick) begin
            tx_idx_q <= tx_idx_q + 3'h1;
            tx_bit_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            if (tx_idx_q == 3'h7) begin
              tx_bit_q <= 1'b1;
              tx_st_q <= SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (tx_tick) begin
            tx_st_q <= SER_IDLE;
          end
        end
        default: begin
          tx_st_q <= SER_IDLE;
        end
      endcase
    end
  end

  // infrared output pulses low for a zero bit, uart output idles high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sout <= 1'b1;
      sir_out_n <= 1'b1;
    end else begin
      sout <= ctrl_q.ir_mode ? 1'b1 : tx_bit_q;
      sir_out_n <= !(ctrl_q.ir_mode && !tx_bit_q);
    end
  end

  // read data, captured in the setup phase
  wire tx_idle = transmit_holding_empty_flag && (tx_st_q == SER_IDLE);
  wire [7:0] rx_head = fifo_en ? rxf_out_data : rx_hold_q;
  wire [31:0] stat_word = {22'h0, !rxf_in_ready, !txf_in_ready, 1'b0, tx_idle,
                           transmit_holding_empty_flag, 3'h0, overrun_q, data_ready};
  wire [31:0] ctrl_word = {30'h0, ctrl_q.ir_mode, ctrl_q.fifo_en};
  wire [31:0] rdata_d = hit_alias ? {24'h0, rx_head} :
                        hit_stat ? stat_word :
                        hit_ctrl ? ctrl_word : 32'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      rd_ok_q <= 1'b0;
    end else if (setup) begin
      prdata <= req.wr ? 32'h0 : rdata_d;
      rd_ok_q <= data_ready;
    end
  end
endmodule : ubb_top

/* tb/test_uart_shadow_rx_tx_buffer.sv */
/*
 test_uart_shadow_rx_tx_buffer: self-checking bench for ubb_top.
 Assumes ubb_top, ubb_link_model and ubb_checker are compiled first.
*/
`timescale 1ns/1ps
module test_uart_shadow_rx_tx_buffer;
  import ubb_pkg::*;
  logic clock;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sin;
  logic sir_in;
  logic sout;
  logic sir_out_n;
  logic got_valid;
  logic [7:0] got_byte;
  logic [7:0] rb;
  logic [65:0] e;
  logic [65:0] rdq[$];
  logic [7:0] txq[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 11634;
  ubb_top uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n));
  // the idle output stands high, so the active one of the two carries the frame
  ubb_link_model link (.clock(clock), .rx_line(sout & sir_out_n), .tx_line(sin),
    .ir_line(sir_in), .got_valid(got_valid), .got_byte(got_byte));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // one transfer; mask and expected {pslverr, prdata} go to rdq
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] m, input logic [32:0] x);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rdq.push_back({m, x});
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {1'b1, 32'h0}, 33'h0);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [32:0] m, input logic [32:0] x);
    apb(1'b0, a, 32'h0, m, x);
  endtask : rd
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      e = rdq.pop_front();
      chk({pslverr, prdata} & e[65:33], e[32:0]);
    end
    if (got_valid) chk({25'h0, got_byte}, txq.size() ? {25'h0, txq.pop_front()} : 33'hx);
  end
  initial begin
    repeat (52 * BIT_CYC) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(STAT_ADDR, {1'b1, 32'h363}, {1'b0, 32'h60});
    rd(32'h5000_1000, {33{1'b1}}, {1'b1, 32'h0});
    fork
      begin
        link.send(8'h3c);
        link.send(8'ha5);
      end
    join_none
    rb = 8'($random(seed));
    txq.push_back(rb);
    wr(ALIAS_5_ADDR, {24'h0, rb});
    repeat (20) @(posedge clock);
    wr(ALIAS_6_ADDR, 32'h11);
    rd(STAT_ADDR, {1'b1, 32'h20}, 33'h0);
    rb = 8'($random(seed));
    txq.push_back(rb);
    wr(ALIAS_BASE, {24'h0, rb});
    repeat (21 * BIT_CYC) @(posedge clock);
    rd(STAT_ADDR, {1'b1, 32'h3}, {1'b0, 32'h3});
    rd(ALIAS_6_ADDR, {33{1'b1}}, {1'b0, 32'ha5});
    rd(STAT_ADDR, {1'b1, 32'h3}, 33'h0);
    wr(CTRL_ADDR, 32'h2);
    fork
      link.send(8'h5a);
    join_none
    rb = 8'($random(seed));
    txq.push_back(rb);
    wr(ALIAS_5_ADDR, {24'h0, rb});
    repeat (12 * BIT_CYC) @(posedge clock);
    rd(ALIAS_6_ADDR, {33{1'b1}}, {1'b0, 32'h5a});
    wr(CTRL_ADDR, 32'h1);
    fork
      link.send(8'h96);
    join_none
    for (int i = 0; i < 18; i++) begin
      rb = 8'($random(seed));
      if (i < 17) txq.push_back(rb);
      wr(ALIAS_BASE + 32'(4 * (i % 16)), {24'h0, rb});
    end
    rd(STAT_ADDR, {1'b1, 32'h100}, {1'b0, 32'h100});
    repeat (12 * BIT_CYC) @(posedge clock);
    rd(ALIAS_LAST, {33{1'b1}}, {1'b0, 32'h96});
    rd(STAT_ADDR, {1'b1, 32'h1}, 33'h0);
    summarize();
  end
endmodule : test_uart_shadow_rx_tx_buffer

/* tb/ubb_assertions.sv */
/*
 ubb_checker: concurrent checks on the ubb_top ports.
 Assumes one clock and rstn asynchronous, active low.
*/
`timescale 1ns/1ps
module ubb_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic sin,
  input wire logic sir_in,
  input wire logic sout,
  input wire logic sir_out_n
);
  import ubb_pkg::*;
  logic [15:0] low_q;
  logic [15:0] low_d;
  logic ir_q;
  logic ir_d;
  wire acc = psel && penable;
  wire alias_hit = paddr >= ALIAS_BASE && paddr <= ALIAS_LAST && paddr[1:0] == 2'b00;
  wire hit = alias_hit || paddr == CTRL_ADDR || paddr == STAT_ADDR;
  // length of the current low run on sout
  assign low_d = sout ? 16'h0 : low_q + 16'h1;
  assign ir_d = (acc && pwrite && paddr == CTRL_ADDR) ? pwdata[CTRL_IR_BIT] : ir_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_q <= 16'h0;
      ir_q <= 1'b0;
    end else begin
      low_q <= low_d;
      ir_q <= ir_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_error: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped access");
  a_error_cause: assert property (pslverr |-> acc && !hit)
    else $error("spurious error response");
  a_alias_upper_zero: assert property (acc && !pwrite && alias_hit |-> prdata[31:8] == 24'h0)
    else $error("alias read upper bits set");
  a_unmapped_read_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_bit_multiple: assert property (sout && low_q != 16'h0 |-> low_q % BIT_CYC == 0)
    else $error("serial low run not whole bits");
  a_ir_quiet: assert property (!ir_q && !$past(ir_q) |-> sir_out_n)
    else $error("infrared output active in serial mode");
  a_sout_ir_idle: assert property (ir_q && $past(ir_q) |-> sout)
    else $error("serial output active in infrared mode");
endmodule : ubb_checker

bind ubb_top ubb_checker u_chk (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n));

/* tb/ubb_link_model.sv */
/*
 ubb_link_model: far-end 8N1 serial partner at the fixed baud rate.
 Assumes its line idles high; send is called from the bench.
*/
`timescale 1ns/1ps
module ubb_link_model (
  // clock
  input wire logic clock,
  // serial lines
  input wire logic rx_line,
  output logic tx_line,
  output logic ir_line,
  // decoded bytes
  output logic got_valid,
  output logic [7:0] got_byte
);
  import ubb_pkg::*;
  initial tx_line = 1'b1;
  // infrared line idles low and stands high for each zero bit
  assign ir_line = !tx_line;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      tx_line <= f[i];
      repeat (BIT_CYC - 11'h1) @(posedge clock);
    end
  endtask : send
  // sample mid-bit; a bad stop bit gives no byte
  initial begin
    got_valid = 1'b0;
    forever begin
      @(posedge clock iff !rx_line);
      repeat (HALF_CYC) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clock);
        got_byte[i] = rx_line;
      end
      repeat (BIT_CYC) @(posedge clock);
      got_valid <= rx_line;
      @(posedge clock);
      got_valid <= 1'b0;
    end
  end
endmodule : ubb_link_model
